// >>> rtl/ac_link_host.v
// AC-Link host controller: frames the codec-supplied bit clock, sends
// tag, command and PCM slots, and captures tag, status and ADC slots.
// Assumes the codec drives bit_clk and sdata_in; software uses a plain
// strobe port with read data one cycle after the read strobe.
`timescale 1ns/100ps
`default_nettype none
`include "ac_link_defs.vh"
module ac_link_host (
  // Clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // Software register port
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [31:0] rdata,
  // AC-Link pins
  input wire bit_clk,
  input wire sdata_in,
  output reg sync,
  output reg sdata_out
);
  // Frame length kept in an integer first, then cut to the counter width on purpose
  localparam integer FRAME_CLKS = `FRAME_LEN;
  localparam [8:0] FRAME_LEN = FRAME_CLKS[8:0];
  localparam [7:0] LAST_POS = FRAME_LEN[7:0] - 8'd1;

  wire bit_rise;
  wire bit_fall;
  wire din;
  wire [19:0] in_word;
  wire [3:0] in_slot;
  wire in_stb;

  // Software-visible state
  reg [3:0] ctrl_ff;
  reg [23:0] cmd_ff;
  reg cmd_pend_ff;
  reg [19:0] pcm_l_ff;
  reg [19:0] pcm_r_ff;
  reg sample_rdy_ff;
  reg read_done_ff;
  reg underrun_ff;
  reg wait_rd_ff;
  reg [6:0] rd_idx_ff;
  reg [15:0] rd_data_ff;
  reg [6:0] rd_ret_idx_ff;
  reg [15:0] in_tag_ff;
  reg [19:0] in_addr_ff;
  reg [19:0] adc_l_ff;
  reg [19:0] adc_r_ff;
  reg req_l_ff;
  reg req_r_ff;

  // Frame engine state
  reg started_ff;
  reg [7:0] pos_ff;
  reg [19:0] sh_ff;
  reg [4:0] left_ff;
  reg [3:0] out_slot_ff;
  reg fr_cmd_ff;
  reg fr_rd_ff;
  reg [6:0] fr_idx_ff;
  reg [15:0] fr_data_ff;
  reg fr_pcm_ff;
  reg [19:0] fr_l_ff;
  reg [19:0] fr_r_ff;

  // Decisions taken at the frame boundary
  reg frame_start;
  reg take_cmd;
  reg need_pcm;
  reg send_pcm;
  reg primary;
  reg [15:0] nxt_tag;
  reg [3:0] nxt_slot;
  reg [19:0] nxt_slot_word;
  reg [31:0] nxt_rdata;
  reg capture_stb;
  reg [7:0] fall_idx;

  ac_pin_sync u_pin_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .bit_clk(bit_clk),
    .sdata_in(sdata_in),
    .bit_rise(bit_rise),
    .bit_fall(bit_fall),
    .data_sync(din)
  );

  ac_in_capture u_in_capture (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .fall_stb(capture_stb),
    .din(din),
    .bit_idx(fall_idx),
    .word(in_word),
    .word_slot(in_slot),
    .word_stb(in_stb)
  );

  always @* begin
    frame_start = ctrl_ff[`CTRL_LINK_EN] & bit_rise & (pos_ff == 8'h00);
    take_cmd = cmd_pend_ff;
    // A stereo pair goes out when either slot was requested last frame
    // Clearing pcm_en stops the sample source ahead of a channel power-down
    need_pcm = ctrl_ff[`CTRL_PCM_EN] & (req_l_ff | req_r_ff);
    send_pcm = need_pcm & sample_rdy_ff;
    primary = (ctrl_ff[`CTRL_ID_HI:`CTRL_ID_LO] == 2'b00);
    nxt_tag = 16'h0000;
    nxt_tag[`TAG_FRAME_VALID] = take_cmd | send_pcm;
    nxt_tag[`TAG_CMD_ADDR] = take_cmd & primary;
    nxt_tag[`TAG_CMD_DATA] = take_cmd & primary;
    nxt_tag[`TAG_PCM_L] = send_pcm;
    nxt_tag[`TAG_PCM_R] = send_pcm;
    if (take_cmd) begin
      nxt_tag[1:0] = ctrl_ff[`CTRL_ID_HI:`CTRL_ID_LO];
    end
    // Receiver side samples at falls; index of the bit on the line
    fall_idx = pos_ff - 8'd2;
    capture_stb = bit_fall & started_ff & ctrl_ff[`CTRL_LINK_EN];
  end

  // Next slot contents; untagged slots stay zero, except slots 1 and 2 which carry a command under a secondary codec ID
  always @* begin
    nxt_slot = out_slot_ff + 4'h1;
    nxt_slot_word = 20'h00000;
    case (nxt_slot)
      4'd1: begin
        if (fr_cmd_ff) begin
          nxt_slot_word = {fr_rd_ff, fr_idx_ff, 12'h000};
        end
      end
      4'd2: begin
        if (fr_cmd_ff && !fr_rd_ff) begin
          nxt_slot_word = {fr_data_ff, 4'h0};
        end
      end
      4'd3: begin
        if (fr_pcm_ff) begin
          nxt_slot_word = fr_l_ff;
        end
      end
      4'd4: begin
        if (fr_pcm_ff) begin
          nxt_slot_word = fr_r_ff;
        end
      end
      default: begin
        nxt_slot_word = 20'h00000;
      end
    endcase
  end

  // Serial frame engine, stepped on detected bit clock rises
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      started_ff <= 1'b0;
      pos_ff <= 8'h00;
      sh_ff <= 20'h00000;
      left_ff <= 5'h00;
      out_slot_ff <= 4'h0;
      sync <= 1'b0;
      sdata_out <= 1'b0;
      fr_cmd_ff <= 1'b0;
      fr_rd_ff <= 1'b0;
      fr_idx_ff <= 7'h00;
      fr_data_ff <= 16'h0000;
      fr_pcm_ff <= 1'b0;
      fr_l_ff <= 20'h00000;
      fr_r_ff <= 20'h00000;
    end else if (!ctrl_ff[`CTRL_LINK_EN]) begin
      // Link idle: sync and data held low
      started_ff <= 1'b0;
      pos_ff <= 8'h00;
      sh_ff <= 20'h00000;
      left_ff <= 5'h00;
      sync <= 1'b0;
      sdata_out <= 1'b0;
    end else if (bit_rise) begin
      started_ff <= 1'b1;
      pos_ff <= (pos_ff == LAST_POS) ? 8'h00 : pos_ff + 8'h01;
      sync <= (pos_ff < `SYNC_HIGH_BITS);
      sdata_out <= sh_ff[19];
      if (pos_ff == 8'h00) begin
        sh_ff <= {nxt_tag, 4'h0};
        left_ff <= `TAG_BITS;
        out_slot_ff <= 4'h0;
        fr_cmd_ff <= take_cmd;
        fr_rd_ff <= cmd_ff[`CMD_W_RD];
        fr_idx_ff <= cmd_ff[`CMD_W_IDX_HI:`CMD_W_IDX_LO];
        fr_data_ff <= cmd_ff[15:0];
        fr_pcm_ff <= send_pcm;
        fr_l_ff <= pcm_l_ff;
        fr_r_ff <= pcm_r_ff;
      end else if (left_ff == 5'h01 && out_slot_ff != `LAST_SLOT) begin
        sh_ff <= nxt_slot_word;
        left_ff <= `SLOT_BITS;
        out_slot_ff <= nxt_slot;
      end else begin
        sh_ff <= {sh_ff[18:0], 1'b0};
        left_ff <= left_ff - 5'h01;
      end
    end
  end

  // Register file; hardware sets are written last so they win
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_ff <= `CTRL_RESET;
      cmd_ff <= 24'h000000;
      cmd_pend_ff <= 1'b0;
      pcm_l_ff <= 20'h00000;
      pcm_r_ff <= 20'h00000;
      sample_rdy_ff <= 1'b0;
      read_done_ff <= 1'b0;
      underrun_ff <= 1'b0;
      wait_rd_ff <= 1'b0;
      rd_idx_ff <= 7'h00;
      rd_data_ff <= 16'h0000;
      rd_ret_idx_ff <= 7'h00;
      in_tag_ff <= 16'h0000;
      in_addr_ff <= 20'h00000;
      adc_l_ff <= 20'h00000;
      adc_r_ff <= 20'h00000;
      req_l_ff <= 1'b1;
      req_r_ff <= 1'b1;
    end else begin
      // Frame boundary consumes the pending command and sample
      if (frame_start) begin
        if (take_cmd) begin
          cmd_pend_ff <= 1'b0;
          if (cmd_ff[`CMD_W_RD]) begin
            wait_rd_ff <= 1'b1;
            rd_idx_ff <= cmd_ff[`CMD_W_IDX_HI:`CMD_W_IDX_LO];
          end
        end
        if (send_pcm) begin
          sample_rdy_ff <= 1'b0;
        end
      end
      if (wr_stb) begin
        case (addr)
          `REG_CTRL: begin
            ctrl_ff <= wdata[3:0];
          end
          `REG_CMD: begin
            cmd_ff <= wdata[23:0];
            cmd_pend_ff <= 1'b1;
          end
          `REG_STATUS: begin
            if (wdata[`ST_READ_DONE]) begin
              read_done_ff <= 1'b0;
            end
            if (wdata[`ST_UNDERRUN]) begin
              underrun_ff <= 1'b0;
            end
          end
          `REG_PCM_L: begin
            pcm_l_ff <= wdata[19:0];
          end
          `REG_PCM_R: begin
            // Writing the right sample completes the pair
            pcm_r_ff <= wdata[19:0];
            sample_rdy_ff <= 1'b1;
          end
          default: begin
          end
        endcase
      end
      if (frame_start && need_pcm && !sample_rdy_ff) begin
        underrun_ff <= 1'b1;
      end
      if (in_stb) begin
        case (in_slot)
          4'd0: begin
            in_tag_ff <= in_word[15:0];
          end
          4'd1: begin
            in_addr_ff <= in_word;
            // Active-low requests feed the next output frame
            req_l_ff <= ~in_word[`SLOT_REQUEST_FLAG_L];
            req_r_ff <= ~in_word[`SLOT_REQUEST_FLAG_R];
          end
          4'd2: begin
            if (wait_rd_ff && in_tag_ff[`TAG_CMD_ADDR] && in_tag_ff[`TAG_CMD_DATA]
                && in_addr_ff[`SLOT1_IDX_HI:`SLOT1_IDX_LO] == rd_idx_ff) begin
              rd_data_ff <= in_word[19:4];
              rd_ret_idx_ff <= in_addr_ff[`SLOT1_IDX_HI:`SLOT1_IDX_LO];
              read_done_ff <= 1'b1;
              wait_rd_ff <= 1'b0;
            end
          end
          4'd3: begin
            if (in_tag_ff[`TAG_PCM_L]) begin
              adc_l_ff <= in_word;
            end
          end
          4'd4: begin
            if (in_tag_ff[`TAG_PCM_R]) begin
              adc_r_ff <= in_word;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always @* begin
    nxt_rdata = 32'h00000000;
    case (addr)
      `REG_CTRL: nxt_rdata = {28'h0000000, ctrl_ff};
      `REG_CMD: nxt_rdata = {8'h00, cmd_ff};
      `REG_STATUS: nxt_rdata = {25'h0000000, wait_rd_ff, req_r_ff, req_l_ff,
                                sample_rdy_ff, cmd_pend_ff, underrun_ff, read_done_ff};
      `REG_RDATA: nxt_rdata = {9'h000, rd_ret_idx_ff, rd_data_ff};
      `REG_PCM_L: nxt_rdata = {12'h000, pcm_l_ff};
      `REG_PCM_R: nxt_rdata = {12'h000, pcm_r_ff};
      `REG_IN_TAG: nxt_rdata = {16'h0000, in_tag_ff};
      `REG_ADC_L: nxt_rdata = {12'h000, adc_l_ff};
      `REG_ADC_R: nxt_rdata = {12'h000, adc_r_ff};
      default: nxt_rdata = 32'h00000000;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata <= 32'h00000000;
    end else begin
      rdata <= rd_stb ? nxt_rdata : 32'h00000000;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/ac_link_defs.vh
// Constants for the AC-Link host controller: register map, field
// positions, reset values and frame geometry.
// Assumes inclusion by bare name from the rtl/ design files.
`ifndef AC_LINK_DEFS_VH
`define AC_LINK_DEFS_VH

// Link rates; the frame length in bit clocks is derived from them
`define BIT_CLK_HZ 12288000
`define FRAME_HZ 48000
`define FRAME_LEN (`BIT_CLK_HZ / `FRAME_HZ)
`define SYNC_HIGH_BITS 8'd16
`define TAG_BITS 5'd16
`define SLOT_BITS 5'd20
`define LAST_SLOT 4'd12

// Host-side register byte addresses
`define REG_CTRL 8'h00
`define REG_CMD 8'h04
`define REG_STATUS 8'h08
`define REG_RDATA 8'h0C
`define REG_PCM_L 8'h10
`define REG_PCM_R 8'h14
`define REG_IN_TAG 8'h18
`define REG_ADC_L 8'h1C
`define REG_ADC_R 8'h20

// CTRL fields
`define CTRL_LINK_EN 0
`define CTRL_PCM_EN 1
`define CTRL_ID_LO 2
`define CTRL_ID_HI 3
`define CTRL_RESET 4'h0

// CMD fields as written by software
`define CMD_W_RD 23
`define CMD_W_IDX_HI 22
`define CMD_W_IDX_LO 16

// STATUS fields
`define ST_READ_DONE 0
`define ST_UNDERRUN 1
`define ST_CMD_PEND 2
`define ST_SAMPLE_RDY 3
`define ST_REQ_L 4
`define ST_REQ_R 5
`define ST_WAIT_RD 6

// Slot 0 tag bits
`define TAG_FRAME_VALID 15
`define TAG_CMD_ADDR 14
`define TAG_CMD_DATA 13
`define TAG_PCM_L 12
`define TAG_PCM_R 11

// Slot 1 fields
`define SLOT1_RD 19
`define SLOT1_IDX_HI 18
`define SLOT1_IDX_LO 12
`define SLOT_REQUEST_FLAG_L 11
`define SLOT_REQUEST_FLAG_R 10

`endif

// >>> rtl/ac_pin_sync.v
// Two-flop synchronisers for the link bit clock and input data pin,
// plus edge detection of the synchronised bit clock.
// Assumes bit clock well below half of sys_clk.
`timescale 1ns/100ps
`default_nettype none
module ac_pin_sync (
  // Clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // Pins
  input wire bit_clk,
  input wire sdata_in,
  // Synchronised results
  output reg bit_rise,
  output reg bit_fall,
  output wire data_sync
);
  wire [1:0] pin_in;
  wire [1:0] pin_sync;
  reg clk_last_ff;

  assign pin_in = {sdata_in, bit_clk};

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_sync
      reg meta_ff;
      reg sync_ff;
      always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          meta_ff <= 1'b0;
          sync_ff <= 1'b0;
        end else begin
          meta_ff <= pin_in[i];
          sync_ff <= meta_ff;
        end
      end
      assign pin_sync[i] = sync_ff;
    end
  endgenerate

  assign data_sync = pin_sync[1];

  // Edges come from the second stage only, never the metastable one
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clk_last_ff <= 1'b0;
      bit_rise <= 1'b0;
      bit_fall <= 1'b0;
    end else begin
      clk_last_ff <= pin_sync[0];
      bit_rise <= pin_sync[0] & ~clk_last_ff;
      bit_fall <= ~pin_sync[0] & clk_last_ff;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/ac_in_capture.v
// Deserialiser for the incoming link stream: collects the 16-bit tag
// and the twelve 20-bit slots, MSB first, and hands each word out.
// Assumes one fall_stb per bit and the frame bit index beside it.
`timescale 1ns/100ps
`default_nettype none
module ac_in_capture (
  // Clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // Serial bit in
  input wire fall_stb,
  input wire din,
  input wire [7:0] bit_idx,
  // Word out
  output reg [19:0] word,
  output reg [3:0] word_slot,
  output reg word_stb
);
  reg [18:0] shift_ff;
  reg [4:0] cnt_ff;
  reg [3:0] slot_ff;
  reg [3:0] eff_slot;
  reg [4:0] eff_cnt;
  reg last_bit;

  always @* begin
    eff_slot = (bit_idx == 8'h00) ? 4'h0 : slot_ff;
    eff_cnt = (bit_idx == 8'h00) ? 5'h00 : cnt_ff;
    last_bit = (eff_slot == 4'h0) ? (eff_cnt == `TAG_BITS - 5'd1)
                                  : (eff_cnt == `SLOT_BITS - 5'd1);
  end

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      shift_ff <= 19'h00000;
      cnt_ff <= 5'h00;
      slot_ff <= 4'h0;
      word <= 20'h00000;
      word_slot <= 4'h0;
      word_stb <= 1'b0;
    end else begin
      word_stb <= 1'b0;
      if (fall_stb) begin
        shift_ff <= {shift_ff[17:0], din};
        if (last_bit) begin
          word <= {shift_ff, din};
          word_slot <= eff_slot;
          word_stb <= 1'b1;
          slot_ff <= eff_slot + 4'h1;
          cnt_ff <= 5'h00;
        end else begin
          slot_ff <= eff_slot;
          cnt_ff <= eff_cnt + 5'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> sim/ac_link_host_props.sv
// Concurrent checks on the host's link pins.
// Assumes a bit clock several sys_clk periods long.
`timescale 1ns/100ps
`default_nettype none
module ac_link_host_props (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Link pins
  input wire logic bit_clk,
  input wire logic sync,
  input wire logic sdata_out
);
  logic r1_ff, r2_ff, seen_ff, rd_ff;
  logic [8:0] cnt_ff;
  logic [2:0] age_ff;
  logic [15:0] tg_ff;
  wire rise = r1_ff & ~r2_ff;
  wire fall = ~r1_ff & r2_ff;
  wire [8:0] slot = (cnt_ff - 9'h011) / 9'h014 + 9'h001;
  wire ph = seen_ff & fall & (cnt_ff >= 9'h011);
  wire at1 = seen_ff & fall & (cnt_ff == 9'h011);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Edge detect two stages shorter than the host's, so counts settle first
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      {r1_ff, r2_ff, seen_ff, rd_ff, cnt_ff, tg_ff} <= '0;
      age_ff <= 3'h7;
    end else begin
      r1_ff <= bit_clk;
      r2_ff <= r1_ff;
      age_ff <= rise ? 3'h0 : (age_ff == 3'h7 ? age_ff : age_ff + 3'h1);
      if ($rose(sync)) begin
        cnt_ff <= 9'h000;
        seen_ff <= 1'h1;
      end else if (rise) begin
        cnt_ff <= cnt_ff + 9'h001;
      end
      if (fall && cnt_ff >= 9'h001 && cnt_ff <= 9'h010) tg_ff <= {tg_ff[14:0], sdata_out};
      if (fall && cnt_ff == 9'h011) rd_ff <= sdata_out;
    end
  end
  chk_frame_len: assert property ($rose(sync) && seen_ff |-> cnt_ff == 9'h100)
    else $error("frame length wrong");
  chk_tag_phase: assert property ($fell(sync) |-> cnt_ff == 9'h010)
    else $error("sync high time wrong");
  chk_tx_edge: assert property ($changed(sdata_out) || $changed(sync) |-> age_ff <= 3'h4)
    else $error("output moved off a rise");
  // Secondary access: the codec ID, not tags 14 and 13, validates slots 1 and 2
  chk_zero_stuff: assert property (ph && !tg_ff[4'hF - slot[3:0]]
    && !(slot <= 9'h002 && tg_ff[1:0] != 2'h0) |-> !sdata_out)
    else $error("invalid slot not zero");
  chk_slot1_pad: assert property (ph && cnt_ff >= 9'h019 && cnt_ff <= 9'h024 |-> !sdata_out)
    else $error("slot 1 padding not zero");
  chk_slot2_pad: assert property (ph && cnt_ff >= 9'h025 && cnt_ff <= 9'h038
    && (rd_ff || cnt_ff >= 9'h035) |-> !sdata_out)
    else $error("slot 2 not zero");
  chk_primary_id: assert property (at1 && tg_ff[14] |-> tg_ff[15] && tg_ff[1:0] == 2'h0)
    else $error("primary tag wrong");
  chk_second_id: assert property (at1 && tg_ff[1:0] != 2'h0 |-> tg_ff[15] && !tg_ff[14])
    else $error("secondary tag wrong");
  cov_primary: cover property (at1 && tg_ff[14]);
  cov_second: cover property (at1 && tg_ff[0]);
  cov_pcm: cover property (at1 && tg_ff[12]);
endmodule
bind ac_link_host ac_link_host_props chk (.sys_clk, .sys_rst, .bit_clk, .sync, .sdata_out);
`default_nettype wire

// >>> sim/ac_codec_model.sv
// Behavioural codec: makes the bit clock, obeys commands, returns frames.
// Assumes the host starts frames with sync and sends MSB first.
`timescale 1ns/100ps
`default_nettype none
module ac_codec_model (
  // Link pins
  output logic bit_clk,
  input wire logic sync,
  input wire logic sdata_out,
  output logic sdata_in,
  // Tag and slots 1 to 4 of the latest valid output frame
  output logic [95:0] oframe
);
  logic [255:0] sh, ifr;
  logic [15:0] regs [0:127];
  logic [7:0] n;
  logic [6:0] ridx;
  logic ps, rpend, fodd;
  logic [1:0] req;
  wire variable_rate_enable = regs[7'h2A][0];
  wire mic_variable_rate_enable = regs[7'h2A][3];
  wire pd = regs[7'h26][9];
  // Rate registers stay at 48 kHz while their variable-rate bit is off
  function automatic logic lk(input logic [6:0] x);
    return x >= 7'h2C && x <= 7'h32 && !variable_rate_enable || x == 7'h34 && !mic_variable_rate_enable;
  endfunction
  initial begin
    foreach (regs[j]) regs[j] = 16'h0000;
    {ps, rpend, fodd, n, ridx, sh, ifr, oframe} = '0;
    bit_clk = 1'h0;
    sdata_in = 1'h0;
    forever #200 bit_clk = ~bit_clk;
  end
  always @(negedge bit_clk) begin
    n = (sync && !ps) ? 8'h00 : n + 8'h01;
    ps = sync;
    sh = {sh[254:0], sdata_out};
    if (n == 8'h00) begin
      fodd = ~fodd;
      req = (variable_rate_enable && !pd) ? {2{fodd}} : 2'h0;
      ifr = {1'h1, rpend, rpend, 13'h1800, 1'h0, rpend ? ridx : 7'h00, req, 10'h000,
        rpend ? {lk(ridx) ? 16'hBB80 : regs[ridx], 4'h0} : 20'h00000,
        20'h12345, 20'h6789A, 160'h0};
      rpend = 1'h0;
    end
    if (n == 8'h60 && sh[95]) begin
      oframe = sh[95:0];
      if (sh[94] && sh[81:80] == 2'h0) begin
        ridx = sh[78:72];
        rpend = sh[79];
        if (!sh[79] && sh[93] && !lk(sh[78:72])) regs[sh[78:72]] = sh[59:44];
      end
    end
  end
  always @(posedge bit_clk) sdata_in <= ifr[8'hFF - n];
endmodule
`default_nettype wire

// >>> sim/ac_link_host_tb.sv
// Self-checking bench for the link host: command table, PCM, power-down.
// Assumes the codec model supplies the bit clock and input frames.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
  $display("wrong value t=%0t got %h exp %h", $time, g, e); n_mismatch++; end end
module ac_link_host_tb;
  logic sys_clk, sys_rst, wr_stb, rd_stb, sync, sdata_out, bit_clk, sdata_in;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, d;
  logic [95:0] oframe;
  int n_mismatch = 0, comparisons = 0, i;
  // Rows: codec register index, write data, read-back value
  logic [38:0] rows [0:4] = '{{7'h02, 16'h1F1F, 16'h1F1F}, {7'h2C, 16'hAC44, 16'hBB80},
    {7'h2A, 16'h0001, 16'h0001}, {7'h2C, 16'hAC44, 16'hAC44}, {7'h34, 16'h1F40, 16'hBB80}};
  ac_link_host uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .bit_clk(bit_clk),
    .sdata_in(sdata_in), .sync(sync), .sdata_out(sdata_out));
  ac_codec_model codec (.bit_clk(bit_clk), .sync(sync), .sdata_out(sdata_out),
    .sdata_in(sdata_in), .oframe(oframe));
  initial begin
    sys_clk = 1'h0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic test_done;
    if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'h1;
    @(posedge sys_clk);
    wr_stb <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    addr <= a;
    rd_stb <= 1'h1;
    @(posedge sys_clk);
    rd_stb <= 1'h0;
    @(negedge sys_clk);
    d = rdata;
  endtask
  // Bounded poll of a status bit, so a dead link cannot hang the run
  task automatic wt(input int b, input logic v);
    for (int k = 0; k < 8000; k++) begin
      rd(8'h08);
      if (d[b] === v) return;
    end
    n_mismatch++;
    test_done;
  endtask
  task automatic wfr(input int b);
    for (int k = 0; k < 4000; k++) begin
      @(posedge sys_clk);
      if (oframe[b] === 1'h1) return;
    end
    n_mismatch++;
    test_done;
  endtask
  task automatic send(input logic [31:0] c);
    wr(8'h04, c);
    wt(2, 1'h0);
  endtask
  task automatic rback(input logic [6:0] x, input logic [15:0] e);
    send({8'h00, 1'h1, x, 16'h0000});
    wt(0, 1'h1);
    rd(8'h0C);
    `CHK(d[22:0], {x, e})
    wr(8'h08, 32'h1);
  endtask
  initial begin
    sys_rst = 1'h1;
    addr = 8'h00;
    wdata = 32'h0;
    wr_stb = 1'h0;
    rd_stb = 1'h0;
    repeat (20) @(posedge sys_clk);
    `CHK({rdata, sync, sdata_out}, 34'h0)
    sys_rst <= 1'h0;
    rd(8'h40);
    `CHK(d, 32'h0)
    wr(8'h00, 32'h1);
    for (i = 0; i < 5; i++) begin
      send({9'h000, rows[i][38:16]});
      rback(rows[i][38:32], rows[i][15:0]);
      `CHK({oframe[95:93], oframe[81:80]}, 5'h1C)
      `CHK(oframe[79:40], {1'h1, rows[i][38:32], 32'h0})
    end
    rd(8'h1C);
    `CHK(d[19:0], 20'h12345)
    rd(8'h20);
    `CHK(d[19:0], 20'h6789A)
    rd(8'h18);
    `CHK({d[15], d[12:0]}, 14'h3800)
    wr(8'h00, 32'h3);
    wt(4, 1'h0);
    wr(8'h10, 32'hA5A5A);
    wr(8'h14, 32'h5A5A5);
    wt(3, 1'h0);
    wfr(92);
    `CHK({oframe[92:91], oframe[39:0]}, {2'h3, 20'hA5A5A, 20'h5A5A5})
    wt(1, 1'h1);
    // Source stopped before the channel is powered down
    wr(8'h00, 32'h1);
    send({9'h000, 7'h26, 16'h0200});
    rback(7'h26, 16'h0200);
    for (i = 0; i < 1000; i++) begin
      rd(8'h08);
      `CHK(d[5:4], 2'h3)
    end
    wr(8'h00, 32'h5);
    send({9'h000, 7'h02, 16'hDEAD});
    wfr(80);
    `CHK({oframe[95:93], oframe[81:80]}, 5'h11)
    wr(8'h00, 32'h1);
    rback(7'h02, 16'h1F1F);
    // Mid-run reset: outputs clear at once and the link stays idle afterwards
    sys_rst <= 1'h1;
    repeat (2) @(posedge sys_clk);
    `CHK({rdata, sync, sdata_out}, 34'h0)
    sys_rst <= 1'h0;
    repeat (600) @(posedge sys_clk);
    `CHK({sync, sdata_out}, 2'h0)
    rd(8'h08);
    `CHK(d, 32'h30)
    test_done;
  end
endmodule
`default_nettype wire
